// >>> shared/dptm_pkg.sv
// Operation
// - two independent pulse channels, zero and one
// - running channel lights indicator, status reads one
// - pulse length is range factor times scale
// - set write to bit starts that channel
// - reset write aborts pulse, status clears
// - status read at same bit as writes
// - controller waits one scan before reading status
package dptm_pkg;
  localparam int unsigned dptm_channels      = 2;
  localparam int unsigned dptm_clk_khz       = 125000;
  // timebase tick: one unit of 0.1 s
  localparam int unsigned dptm_tick_ms       = 100;
  localparam int unsigned dptm_tick_cycles   = dptm_tick_ms * dptm_clk_khz;
  localparam int unsigned dptm_scale_width   = 4;
  localparam int unsigned dptm_count_width   = 16;
  // range factors in ticks: x 0.3 s, x 3 s, x 30 s
  localparam logic [15:0] dptm_range_0p3_ticks = 16'h0003;
  localparam logic [15:0] dptm_range_3_ticks   = 16'h001e;
  localparam logic [15:0] dptm_range_30_ticks  = 16'h012c;
  typedef enum logic [1:0] {
    dptm_range_0p3_type_val,
    dptm_range_3_type_val,
    dptm_range_30_type_val
  } dptm_range_type;
  typedef enum logic [1:0] {
    dptm_op_none,
    dptm_op_set,
    dptm_op_reset
  } dptm_op_type;
endpackage

// >>> shared/dptm_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dptm_if;
  import dptm_pkg::*;
  logic              wr_valid;
  dptm_op_type       wr_op;
  logic              wr_bit;
  logic [1:0]        status;
  modport device (input wr_valid, input wr_op, input wr_bit, output status);
  modport ctrl   (output wr_valid, output wr_op, output wr_bit, input status);
endinterface
`default_nettype wire

// >>> hw/dptm_device.sv
`timescale 1ns/1ns
`default_nettype none
module dptm_device #(
  parameter int unsigned tick_cycles = dptm_pkg::dptm_tick_cycles
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  dptm_if.device                     bus,
  input  wire dptm_pkg::dptm_range_type range_sel [2],
  input  wire logic [dptm_pkg::dptm_scale_width-1:0] scale [2],
  output logic [1:0]                 indicator
);
  import dptm_pkg::*;

  // width of the timebase divider; wide enough for a full 0.1 s count
  localparam int unsigned tick_width = 27;

  localparam logic [tick_width-1:0] tick_last = tick_width'(tick_cycles - 1);

  logic [tick_width-1:0] tick_count;

  logic [tick_width-1:0] next_tick_count;

  logic                  tick_wrap;

  logic                  tick;

  wire logic [1:0]       running;

  // divider wraps once per tick period
  assign tick_wrap = (tick_count == tick_last);

  always_comb begin
    if (tick_wrap) begin
      next_tick_count = 27'h0000000;
    end else begin
      next_tick_count = tick_count + 27'h0000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 27'h0000000;
    end else begin
      tick_count <= next_tick_count;
    end
  end

  // shared 0.1 s enable pulse, one cycle wide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= tick_wrap;
    end
  end

  genvar ch;

  generate
    for (ch = 0; ch < dptm_channels; ch++) begin : g_chan

      logic [dptm_count_width-1:0] factor;

      logic [dptm_count_width-1:0] length;

      logic [dptm_count_width-1:0] remain;

      logic [dptm_count_width-1:0] next_remain;

      logic                        run;

      logic                        next_run;

      logic                        hit;

      logic                        req_set;

      logic                        req_clr;

      logic                        expire;

      assign hit = bus.wr_valid && (bus.wr_bit == 1'(ch));

      assign req_clr = hit && (bus.wr_op == dptm_op_reset);

      assign req_set = hit && (bus.wr_op == dptm_op_set);

      // last tick of the pulse
      assign expire = run && tick && (remain <= 16'h0001);

      always_comb begin
        case (range_sel[ch])
          dptm_range_0p3_type_val: begin
            factor = dptm_range_0p3_ticks;
          end
          dptm_range_3_type_val: begin
            factor = dptm_range_3_ticks;
          end
          dptm_range_30_type_val: begin
            factor = dptm_range_30_ticks;
          end
          default: begin
            factor = dptm_range_0p3_ticks;
          end
        endcase
      end

      // pulse length in ticks is range factor times scale
      assign length = 16'(factor * scale[ch]);

      always_comb begin
        next_run    = run;
        next_remain = remain;
        if (req_clr) begin
          next_run    = 1'b0;
          next_remain = 16'h0000;
        end else if (req_set && !run) begin
          // a zero length start is refused
          next_run    = (length != 16'h0000);
          next_remain = length;
        end else if (expire) begin
          next_run    = 1'b0;
          next_remain = 16'h0000;
        end else if (run && tick) begin
          next_remain = remain - 16'h0001;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          run <= 1'b0;
        end else begin
          run <= next_run;
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          remain <= 16'h0000;
        end else begin
          remain <= next_remain;
        end
      end

      assign running[ch] = run;

    end
  endgenerate

  // status registered, so a start shows one cycle after the channel runs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.status <= 2'h0;
    end else begin
      bus.status <= running;
    end
  end

  // indicator follows the same running state as status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indicator <= 2'h0;
    end else begin
      indicator <= running;
    end
  end

endmodule
`default_nettype wire

// >>> hw/dptm_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module dptm_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  dptm_if.ctrl                       bus,
  input  wire logic                  cmd_valid,
  input  wire dptm_pkg::dptm_op_type cmd_op,
  input  wire logic                  cmd_bit,
  input  wire logic                  scan,
  output logic [1:0]                 running,
  output logic [1:0]                 status_valid
);
  import dptm_pkg::*;

  logic [1:0]      started_this_scan;
  logic [1:0]      set_now;
  wire logic [1:0] settling;

  assign set_now = {2{cmd_valid && cmd_op == dptm_op_set}} & {cmd_bit, !cmd_bit};

  // status lags a start by a few cycles; distrust it until it has landed
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_settle
      logic [1:0] count;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          count <= 2'h0;
        end else if (set_now[ch]) begin
          count <= 2'h2;
        end else if (count != 2'h0) begin
          count <= count - 2'h1;
        end
      end
      assign settling[ch] = (count != 2'h0);
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.wr_valid <= 1'b0;
      bus.wr_op    <= dptm_op_none;
      bus.wr_bit   <= 1'b0;
    end else begin
      bus.wr_valid <= cmd_valid;
      bus.wr_op    <= cmd_op;
      bus.wr_bit   <= cmd_bit;
    end
  end

  // a channel started in this scan is not trusted until the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_this_scan <= 2'h0;
    end else if (scan) begin
      started_this_scan <= 2'h0;
    end else begin
      started_this_scan <= started_this_scan | set_now;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running      <= 2'h0;
      status_valid <= 2'h0;
    end else if (scan) begin
      running      <= bus.status;
      status_valid <= ~(started_this_scan | set_now | settling);
    end
  end
endmodule
`default_nettype wire

// >>> tb/dptm_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module dptm_assertions (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  wr_valid,
  input wire dptm_pkg::dptm_op_type wr_op,
  input wire logic                  wr_bit,
  input wire logic [1:0]            status
);
  import dptm_pkg::*;
  logic [1:0] set_w;
  logic [1:0] clr_w;
  assign set_w = {2{wr_valid && wr_op == dptm_op_set}} & {wr_bit, !wr_bit};
  assign clr_w = {2{wr_valid && wr_op == dptm_op_reset}} & {wr_bit, !wr_bit};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  start_ch0_a: assert property ($rose(status[0]) |-> $past(set_w[0], 2))
    else $error("ch0 rose without start");
  start_ch1_a: assert property ($rose(status[1]) |-> $past(set_w[1], 2))
    else $error("ch1 rose without start");
  abort_ch0_a: assert property (clr_w[0] |-> ##2 !status[0])
    else $error("ch0 abort late");
  abort_ch1_a: assert property (clr_w[1] |-> ##2 !status[1])
    else $error("ch1 abort late");
  op_defined_a: assert property (wr_valid |-> wr_op != dptm_op_none)
    else $error("write without op");
  hold_ch0_a: assert property (clr_w[0] ##1 !wr_valid |-> ##1 !status[0] [*2])
    else $error("ch0 back after abort");
  hold_ch1_a: assert property (clr_w[1] ##1 !wr_valid |-> ##1 !status[1] [*2])
    else $error("ch1 back after abort");
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dptm_pkg::*;
  logic           clk = 0;
  logic           rst_n = 0;
  logic           cmd_valid = 0;
  dptm_op_type    cmd_op = dptm_op_none;
  logic           cmd_bit = 0;
  logic           scan = 0;
  dptm_range_type rs [2] = '{default: dptm_range_0p3_type_val};
  logic [3:0]     sc [2] = '{default: 4'h1};
  logic [1:0]     ind;
  logic [1:0]     ctl_running;
  logic [1:0]     ctl_valid;
  int             n_errors = 0;
  int             n_checks = 0;
  dptm_if bus ();
  dptm_device #(.tick_cycles(4)) i_dptm_device (.clk(clk), .rst_n(rst_n), .bus(bus),
    .range_sel(rs), .scale(sc), .indicator(ind));
  dptm_ctrl i_dptm_ctrl (.clk(clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_bit(cmd_bit), .scan(scan), .running(ctl_running),
    .status_valid(ctl_valid));
  dptm_assertions i_dptm_assertions (.clk(clk), .rst_n(rst_n), .wr_valid(bus.wr_valid),
    .wr_op(bus.wr_op), .wr_bit(bus.wr_bit), .status(bus.status));
  always #4 clk = ~clk;
  always @(posedge clk) scan <= 1'($urandom);
  function automatic int plen(input int r, input int s);
    return s * 4 * (r == 0 ? 3 : r == 1 ? 30 : 300);
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one request, then wait until its status edge has landed
  task cmd(input dptm_op_type op, input logic b);
    @(posedge clk);
    cmd_valid <= 1;
    cmd_op <= op;
    cmd_bit <= b;
    @(posedge clk);
    cmd_valid <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    int n;
    int l;
    time t;
    void'($urandom(77));
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      l = plen(i / 2, $urandom_range(15, 1));
      rs[i%2] <= dptm_range_type'(i / 2);
      sc[i%2] <= 4'(l / (4 * (i < 2 ? 3 : i < 4 ? 30 : 300)));
      cmd(dptm_op_set, i[0]);
      check({bus.status[i%2], ind[i%2]}, 2'h3);
      t = $time;
      repeat (l / 8) @(posedge clk);
      cmd(dptm_op_set, i[0]);
      n = 0;
      while (bus.status[i%2] === 1'b1 && n < 20000) begin
        @(posedge clk);
        #1;
        n++;
      end
      if (bus.status[i%2] === 1'b1) begin
        n_errors++;
        summarize;
      end
      n = int'(($time - t) / 8);
      check(n + 4 >= l && n + 1 <= l, 1);
      $display("pulse test %0d len %0d", i, n);
    end
    sc[0] <= 4'h0;
    cmd(dptm_op_set, 0);
    check({bus.status[0], ind[0]}, 2'h0);
    sc[0] <= 4'hf;
    cmd(dptm_op_set, 0);
    cmd(dptm_op_set, 1);
    cmd(dptm_op_reset, 1);
    check({bus.status, ind}, 4'h5);
    cmd(dptm_op_reset, 0);
    check(bus.status, 0);
    repeat (40) @(posedge clk);
    #1;
    check({ctl_running, ctl_valid}, 4'h3);
    $display("abort test done");
    summarize;
  end
endmodule
`default_nettype wire
